// ===== core/ttu_consts.svh
// constants of the trace and trigger unit: offsets, reset values, field positions
`ifndef TTU_CONSTS_SVH
`define TTU_CONSTS_SVH

// ---------------------------------------------------------------
// register offsets (absolute cpu addresses)
// ---------------------------------------------------------------
`define TTU_COMPARATOR_A_HIGH_BYTE   16'h3010
`define TTU_COMPARATOR_A_LOW_BYTE    16'h3011
`define TTU_COMPARATOR_B_HIGH_BYTE   16'h3012
`define TTU_COMPARATOR_B_LOW_BYTE    16'h3013
`define TTU_COMPARATOR_C_HIGH_BYTE   16'h3014
`define TTU_COMPARATOR_C_LOW_BYTE    16'h3015
`define TTU_TRACE_FIFO_HIGH_BYTE     16'h3016
`define TTU_TRACE_FIFO_LOW_BYTE      16'h3017
`define TTU_COMPARATOR_A_EXTENSION   16'h3018
`define TTU_COMPARATOR_B_EXTENSION   16'h3019
`define TTU_COMPARATOR_C_EXTENSION   16'h301A
`define TTU_TRACE_FIFO_EXTENDED_INFO 16'h301B
`define TTU_TRACE_CONTROL            16'h301C
`define TTU_TRIGGER_SETUP            16'h301D
`define TTU_TRACE_STATUS             16'h301E
`define TTU_TRACE_WORD_COUNT         16'h301F

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define TTU_RST_CMP_A_HI 8'hFF
`define TTU_RST_CMP_A_LO 8'hFE
`define TTU_RST_ZERO     8'h00
`define TTU_RST_CTRL     8'hC0
`define TTU_RST_TRIG     8'h40

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define TTU_CTL_EN      7
`define TTU_CTL_ARM     6
`define TTU_CTL_BRK     5
`define TTU_CTL_TAG     4
`define TTU_CTL_CBRK    3
`define TTU_CTL_LOOP    2
`define TTU_TRG_RSTBEG  7
`define TTU_TRG_BEGIN   6
`define TTU_TRG_FULL    5
`define TTU_TRG_MODE_HI 3
`define TTU_STS_ARMED   7
`define TTU_STS_TRIG    6
`define TTU_STS_ASEEN   5
`define TTU_STS_FULL    1
`define TTU_STS_EMPTY   0

// ---------------------------------------------------------------
// sizes
// ---------------------------------------------------------------
`define TTU_ADDR_W     21
`define TTU_EXT_W      5
`define TTU_FIFO_DEPTH 4

`endif

// ===== core/ttu_pkg.sv
// types shared by the trace and trigger unit
`include "ttu_consts.svh"
package ttu_pkg;
   typedef logic [`TTU_ADDR_W-1:0] ttu_addr_t;
   // trigger modes, encoded in the low nibble of trigger_setup
   typedef enum logic [3:0] {
      TM_A = 4'h0, TM_A_OR_B = 4'h1, TM_A_THEN_B = 4'h2,
      TM_A_AND_D = 4'h3, TM_A_NOT_D = 4'h4, TM_EVT_B = 4'h5,
      TM_A_THEN_EVT = 4'h6, TM_INSIDE = 4'h7, TM_OUTSIDE = 4'h8
   } ttu_mode_t;
   typedef enum {ST_IDLE, ST_WAIT, ST_PRE, ST_POST, ST_DONE} ttu_state_t;
   typedef enum logic [2:0] {
      CK_BRANCH, CK_JMP_IND, CK_JSR_IND, CK_IRQ, CK_RTI, CK_RTC, CK_RTS
   } ttu_cof_kind_t;
   typedef struct packed {
      logic      valid;
      logic      fetch;
      ttu_addr_t addr;
      logic [7:0] data;
   } ttu_bus_t;
   typedef struct packed {
      logic          valid;
      ttu_cof_kind_t kind;
      ttu_addr_t     src;
      ttu_addr_t     dst;
   } ttu_cof_t;
   typedef struct packed {
      logic [7:0] ext;
      logic [7:0] hi;
      logic [7:0] lo;
   } ttu_word_t;
endpackage

// ===== core/ttu_core.sv
// trace and trigger unit: comparators, trigger modes, trace fifo, registers
`timescale 1ns/1ps
`default_nettype none
`include "ttu_consts.svh"

// ---------------------------------------------------------------
// trace fifo, flip-flop storage
// ---------------------------------------------------------------
module ttu_fifo #(
   parameter int W = 24,
   parameter int D = `TTU_FIFO_DEPTH
) (
   input  wire logic                   i_sys_clk,
   input  wire logic                   i_rst_n,
   input  wire logic                   i_clr,
   input  wire logic                   i_in_valid,
   output logic                        o_in_ready,
   input  wire logic [W-1:0]           i_in_data,
   output logic                        o_out_valid,
   input  wire logic                   i_out_ready,
   output logic [W-1:0]                o_out_data,
   output logic [$clog2(D+1)-1:0]      o_count
);
   localparam int AW = (D > 1) ? $clog2(D) : 1;
   localparam int CW = $clog2(D + 1);
   logic [W-1:0]  mem_r [D];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [CW-1:0] cnt_r;
   logic          push;
   logic          pop;

   // honest flags straight from the occupancy count
   assign o_in_ready  = (cnt_r != CW'(D));
   assign o_out_valid = (cnt_r != '0);
   assign o_out_data  = mem_r[rd_ptr_r];
   assign o_count     = cnt_r;
   assign push        = i_in_valid & o_in_ready;
   assign pop         = i_out_ready & o_out_valid;

   // pointers and count; clear drops everything held
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         cnt_r    <= '0;
      end else if (i_clr) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         cnt_r    <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= (wr_ptr_r == AW'(D - 1)) ? '0 : wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= (rd_ptr_r == AW'(D - 1)) ? '0 : rd_ptr_r + 1'b1;
         end
         if (push && !pop) begin
            cnt_r <= cnt_r + 1'b1;
         end else if (pop && !push) begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end

   // storage words, no reset needed
   always_ff @(posedge i_sys_clk) begin
      if (push) begin
         mem_r[wr_ptr_r] <= i_in_data;
      end
   end
endmodule

// ---------------------------------------------------------------
// unit top
// ---------------------------------------------------------------
module ttu_core #(
   parameter int FIFO_DEPTH = `TTU_FIFO_DEPTH
) (
   input  wire logic            i_sys_clk,
   input  wire logic            i_rst_n,
   input  wire logic            i_mcu_rst,
   input  wire logic            i_end_run_rst,
   input  wire logic            i_secure,
   input  wire logic            i_bdm_busy,
   input  wire ttu_pkg::ttu_bus_t i_bus,
   input  wire ttu_pkg::ttu_cof_t i_cof,
   input  wire logic            i_tag_exec,
   input  wire logic [15:0]     i_reg_addr,
   input  wire logic            i_reg_wr,
   input  wire logic            i_reg_rd,
   input  wire logic [7:0]      i_reg_wdata,
   output logic [7:0]           o_reg_rdata,
   output logic                 o_break_req,
   output logic                 o_tag_req,
   output logic                 o_trace_active
);
   import ttu_pkg::*;
   localparam int CW = $clog2(FIFO_DEPTH + 1);

   logic [7:0] cah_r, cal_r, cbh_r, cbl_r, cch_r, ccl_r;
   logic [7:0] cax_r, cbx_r, ccx_r, ctl_r, trg_r;
   ttu_state_t st_r;
   logic       a_seen_r;
   logic       trig_seen_r;
   logic       tag_pend_r;
   logic       cap_vld_r;
   ttu_word_t  cap_word_r;
   ttu_addr_t  cmp_a, cmp_b, cmp_c, cof_addr;
   ttu_mode_t  mode;
   ttu_word_t  head;
   logic       active, gate, full_md, d_eq;
   logic       m_a, m_b, m_c, in_rng, hit, evt_md;
   logic       go, fire, brk_c, evt_st, cof_st, capt, loop_upd;
   logic       in_rdy, out_vld, pop_rd, drop, fclr;
   logic [CW-1:0] cnt;

   // ---------------------------------------------------------------
   // comparators
   // ---------------------------------------------------------------
   // extension bits carry address bits 20 to 16
   assign cmp_a = {cax_r[`TTU_EXT_W-1:0], cah_r, cal_r};
   assign cmp_b = {cbx_r[`TTU_EXT_W-1:0], cbh_r, cbl_r};
   assign cmp_c = {ccx_r[`TTU_EXT_W-1:0], cch_r, ccl_r};
   assign mode    = ttu_mode_t'(trg_r[`TTU_TRG_MODE_HI:0]);
   assign full_md = trg_r[`TTU_TRG_FULL];
   assign active  = ctl_r[`TTU_CTL_EN] & ~i_secure;
   assign gate    = active & ~i_bdm_busy & i_bus.valid;
   // whole-word equality, one bus cycle
   assign m_a  = gate & (i_bus.addr == cmp_a);
   // data compare ignores the B high byte
   assign d_eq = (i_bus.data == cbl_r);
   assign m_b  = full_md ? (gate & d_eq)
                         : (gate & (i_bus.addr == cmp_b));
   assign m_c  = gate & (i_bus.addr == cmp_c);
   assign in_rng = (i_bus.addr >= cmp_a) && (i_bus.addr <= cmp_b);
   assign evt_md = (mode == TM_EVT_B) || (mode == TM_A_THEN_EVT);

   // trigger condition per mode
   always_comb begin
      case (mode)
         TM_A:          hit = m_a;
         TM_A_OR_B:     hit = m_a | m_b;
         TM_A_THEN_B:   hit = a_seen_r & m_b;
         TM_A_AND_D:    hit = full_md & m_a & d_eq;
         TM_A_NOT_D:    hit = full_md & m_a & ~d_eq;
         TM_EVT_B:      hit = m_b;
         TM_A_THEN_EVT: hit = a_seen_r & m_b;
         TM_INSIDE:     hit = gate & in_rng;
         TM_OUTSIDE:    hit = gate & ~in_rng;
         default:       hit = 1'b0;
      endcase
   end

   // ---------------------------------------------------------------
   // trace sequencing
   // ---------------------------------------------------------------
   assign go   = (st_r == ST_IDLE) & active & ctl_r[`TTU_CTL_ARM];
   assign fire = hit & ((st_r == ST_WAIT) | (st_r == ST_PRE));
   // c breaks only when not tracking loops
   assign brk_c = ~ctl_r[`TTU_CTL_LOOP] & ctl_r[`TTU_CTL_CBRK] & m_c;
   assign fclr  = go | i_mcu_rst;

   // state walk; a normal reset abandons the trace
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_r <= ST_IDLE;
      end else if (i_mcu_rst) begin
         st_r <= ST_IDLE;
      end else if (i_end_run_rst) begin
         // end-trace freezes at reset, begin-trace may start here
         case (st_r)
            ST_PRE:  st_r <= ST_DONE;
            ST_WAIT: st_r <= trg_r[`TTU_TRG_RSTBEG] ? ST_POST : ST_WAIT;
            default: st_r <= st_r;
         endcase
      end else if (!active || !ctl_r[`TTU_CTL_ARM]) begin
         st_r <= ST_IDLE;
      end else begin
         case (st_r)
            ST_IDLE: begin
               if (go) begin
                  st_r <= (trg_r[`TTU_TRG_BEGIN] | evt_md) ? ST_WAIT : ST_PRE;
               end
            end
            ST_WAIT: begin
               if (hit) begin
                  st_r <= ST_POST;
               end
            end
            ST_PRE: begin
               if (hit) begin
                  st_r <= ST_DONE;
               end
            end
            ST_POST: begin
               if (cnt == CW'(FIFO_DEPTH)) begin
                  st_r <= ST_DONE;
               end
            end
            ST_DONE: st_r <= ST_DONE;
            default: st_r <= ST_IDLE;
         endcase
      end
   end

   // sequence and trigger flags; a new event beats the clear
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         a_seen_r    <= 1'b0;
         trig_seen_r <= 1'b0;
      end else begin
         if (m_a && st_r != ST_IDLE && st_r != ST_DONE) begin
            a_seen_r <= 1'b1;
         end else if (go || i_mcu_rst) begin
            a_seen_r <= 1'b0;
         end
         if (fire) begin
            trig_seen_r <= 1'b1;
         end else if (go || i_mcu_rst) begin
            trig_seen_r <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // breakpoints
   // ---------------------------------------------------------------
   // forced breaks leave at once, tagged ones wait for execution
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_break_req <= 1'b0;
         o_tag_req   <= 1'b0;
         tag_pend_r  <= 1'b0;
      end else begin
         o_tag_req   <= 1'b0;
         o_break_req <= 1'b0;
         if ((fire & ctl_r[`TTU_CTL_BRK]) | brk_c) begin
            if (ctl_r[`TTU_CTL_TAG]) begin
               o_tag_req  <= i_bus.fetch;
               tag_pend_r <= i_bus.fetch;
            end else begin
               o_break_req <= 1'b1;
            end
         end else if (tag_pend_r && (i_tag_exec || !active)) begin
            o_break_req <= i_tag_exec & active;
            tag_pend_r  <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // capture into the fifo
   // ---------------------------------------------------------------
   // branches record where they left, others where they land
   assign cof_addr = (i_cof.kind == CK_BRANCH) ? i_cof.src
                                               : i_cof.dst;
   assign evt_st = evt_md & hit & ((st_r == ST_WAIT) | (st_r == ST_POST));
   // loop mode skips a repeat of the last stored flow
   assign cof_st = ~evt_md & active & i_cof.valid & ~i_bdm_busy
                 & ((st_r == ST_PRE) | (st_r == ST_POST))
                 & ~(ctl_r[`TTU_CTL_LOOP] & (cof_addr == cmp_c));
   // one staging word; a second event while it is stuck is lost
   assign capt     = (evt_st | cof_st) & (~cap_vld_r | in_rdy);
   assign loop_upd = capt & cof_st & ctl_r[`TTU_CTL_LOOP];
   // pre-trigger trace keeps the newest words by discarding oldest
   assign drop   = (st_r == ST_PRE) & cap_vld_r & ~in_rdy;
   assign pop_rd = i_reg_rd & (i_reg_addr == `TTU_TRACE_FIFO_LOW_BYTE) & out_vld;

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cap_vld_r  <= 1'b0;
         cap_word_r <= '0;
      end else if (fclr) begin
         cap_vld_r <= 1'b0;
      end else if (capt) begin
         cap_vld_r <= 1'b1;
         if (evt_st) begin
            cap_word_r <= '{ext: 8'h00, hi: 8'h00, lo: i_bus.data};
         end else begin
            cap_word_r <= '{ext: 8'(cof_addr[`TTU_ADDR_W-1:16]),
                            hi: cof_addr[15:8], lo: cof_addr[7:0]};
         end
      end else if (in_rdy) begin
         cap_vld_r <= 1'b0;
      end
   end

   ttu_fifo #(
      .W ($bits(ttu_word_t)),
      .D (FIFO_DEPTH)
   ) u_fifo (
      .i_sys_clk   (i_sys_clk),
      .i_rst_n     (i_rst_n),
      .i_clr       (fclr),
      .i_in_valid  (cap_vld_r),
      .o_in_ready  (in_rdy),
      .i_in_data   (cap_word_r),
      .o_out_valid (out_vld),
      .i_out_ready (pop_rd | drop),
      .o_out_data  (head),
      .o_count     (cnt)
   );

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   // normal resets reload, end-run reset leaves contents alone
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cah_r <= `TTU_RST_CMP_A_HI;
         cal_r <= `TTU_RST_CMP_A_LO;
         {cbh_r, cbl_r, cch_r, ccl_r} <= {4{`TTU_RST_ZERO}};
         {cax_r, cbx_r, ccx_r} <= {3{`TTU_RST_ZERO}};
         ctl_r <= `TTU_RST_CTRL;
         trg_r <= `TTU_RST_TRIG;
      end else if (i_mcu_rst) begin
         cah_r <= `TTU_RST_CMP_A_HI;
         cal_r <= `TTU_RST_CMP_A_LO;
         {cbh_r, cbl_r, cch_r, ccl_r} <= {4{`TTU_RST_ZERO}};
         {cax_r, cbx_r, ccx_r} <= {3{`TTU_RST_ZERO}};
         ctl_r <= `TTU_RST_CTRL;
         trg_r <= `TTU_RST_TRIG;
      end else if (!i_end_run_rst) begin
         if (i_reg_wr) begin
            case (i_reg_addr)
               `TTU_COMPARATOR_A_HIGH_BYTE: cah_r <= i_reg_wdata;
               `TTU_COMPARATOR_A_LOW_BYTE:  cal_r <= i_reg_wdata;
               `TTU_COMPARATOR_B_HIGH_BYTE: cbh_r <= i_reg_wdata;
               `TTU_COMPARATOR_B_LOW_BYTE:  cbl_r <= i_reg_wdata;
               `TTU_COMPARATOR_C_HIGH_BYTE: cch_r <= i_reg_wdata;
               `TTU_COMPARATOR_C_LOW_BYTE:  ccl_r <= i_reg_wdata;
               `TTU_COMPARATOR_A_EXTENSION: cax_r <= i_reg_wdata;
               `TTU_COMPARATOR_B_EXTENSION: cbx_r <= i_reg_wdata;
               `TTU_COMPARATOR_C_EXTENSION: ccx_r <= i_reg_wdata;
               `TTU_TRACE_CONTROL:          ctl_r <= i_reg_wdata;
               `TTU_TRIGGER_SETUP:          trg_r <= i_reg_wdata;
               default: ;
            endcase
         end
         // hardware loop tracking overrides a same-cycle write to c
         if (loop_upd) begin
            ccx_r <= 8'(cof_addr[`TTU_ADDR_W-1:16]);
            cch_r <= cof_addr[15:8];
            ccl_r <= cof_addr[7:0];
         end
      end
   end

   // read data registered one cycle after the strobe, zero otherwise
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_reg_rdata <= 8'h00;
      end else if (!i_reg_rd) begin
         o_reg_rdata <= 8'h00;
      end else begin
         case (i_reg_addr)
            `TTU_COMPARATOR_A_HIGH_BYTE: o_reg_rdata <= cah_r;
            `TTU_COMPARATOR_A_LOW_BYTE:  o_reg_rdata <= cal_r;
            `TTU_COMPARATOR_B_HIGH_BYTE: o_reg_rdata <= cbh_r;
            `TTU_COMPARATOR_B_LOW_BYTE:  o_reg_rdata <= cbl_r;
            `TTU_COMPARATOR_C_HIGH_BYTE: o_reg_rdata <= cch_r;
            `TTU_COMPARATOR_C_LOW_BYTE:  o_reg_rdata <= ccl_r;
            `TTU_TRACE_FIFO_HIGH_BYTE:   o_reg_rdata <= out_vld ? head.hi : 8'h00;
            `TTU_TRACE_FIFO_LOW_BYTE:    o_reg_rdata <= out_vld ? head.lo : 8'h00;
            `TTU_COMPARATOR_A_EXTENSION: o_reg_rdata <= cax_r;
            `TTU_COMPARATOR_B_EXTENSION: o_reg_rdata <= cbx_r;
            `TTU_COMPARATOR_C_EXTENSION: o_reg_rdata <= ccx_r;
            `TTU_TRACE_FIFO_EXTENDED_INFO: o_reg_rdata <= out_vld ? head.ext : 8'h00;
            `TTU_TRACE_CONTROL:          o_reg_rdata <= ctl_r;
            `TTU_TRIGGER_SETUP:          o_reg_rdata <= trg_r;
            `TTU_TRACE_STATUS: begin
               o_reg_rdata <= 8'h00;
               o_reg_rdata[`TTU_STS_ARMED] <= (st_r != ST_IDLE) && (st_r != ST_DONE);
               o_reg_rdata[`TTU_STS_TRIG]  <= trig_seen_r;
               o_reg_rdata[`TTU_STS_ASEEN] <= a_seen_r;
               o_reg_rdata[`TTU_STS_FULL]  <= ~in_rdy;
               o_reg_rdata[`TTU_STS_EMPTY] <= ~out_vld;
            end
            `TTU_TRACE_WORD_COUNT:       o_reg_rdata <= 8'(cnt);
            default:                     o_reg_rdata <= 8'h00;
         endcase
      end
   end

   // trace activity flag for the outside world
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_trace_active <= 1'b0;
      end else begin
         o_trace_active <= (st_r == ST_WAIT) | (st_r == ST_PRE) | (st_r == ST_POST);
      end
   end
endmodule

`default_nettype wire

// ===== tb/ttu_chk.sv
// port checker for the trace and trigger unit
`timescale 1ns/1ps
`default_nettype none
module ttu_chk (
   input wire logic              i_sys_clk,
   input wire logic              i_rst_n,
   input wire logic              i_mcu_rst,
   input wire logic              i_end_run_rst,
   input wire logic              i_secure,
   input wire logic              i_bdm_busy,
   input wire ttu_pkg::ttu_bus_t i_bus,
   input wire ttu_pkg::ttu_cof_t i_cof,
   input wire logic              i_tag_exec,
   input wire logic [15:0]       i_reg_addr,
   input wire logic              i_reg_wr,
   input wire logic              i_reg_rd,
   input wire logic [7:0]        i_reg_wdata,
   input wire logic [7:0]        o_reg_rdata,
   input wire logic              o_break_req,
   input wire logic              o_tag_req,
   input wire logic              o_trace_active
);
   import ttu_pkg::*;
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);
   // ---------------------------------------------------------------
   // port relations
   // ---------------------------------------------------------------
   secure_quiet_a: assert property (i_secure |=> !o_break_req && !o_tag_req)
      else $error("break while secured");
   bdm_no_tag_a: assert property (i_bdm_busy |=> !o_tag_req)
      else $error("tag during background command");
   bdm_no_brk_a: assert property (i_bdm_busy && !i_tag_exec |=> !o_break_req)
      else $error("match break during background command");
   tag_needs_fetch_a: assert property (o_tag_req |-> $past(i_bus.valid && i_bus.fetch))
      else $error("tag without opcode fetch");
   tag_single_a: assert property (o_tag_req |=> !o_tag_req)
      else $error("tag pulse too long");
   mcu_idle_a: assert property (i_mcu_rst |-> ##2 !o_trace_active)
      else $error("trace active after reset");
   // a read of comparator A two cycles after a reset must show its reset value
   cah_reset_a: assert property (i_reg_rd && i_reg_addr == 16'h3010 && $past(i_mcu_rst, 2)
      |=> o_reg_rdata == 8'hFF) else $error("high byte of A not FF");
   cal_reset_a: assert property (i_reg_rd && i_reg_addr == 16'h3011 && $past(i_mcu_rst, 2)
      |=> o_reg_rdata == 8'hFE) else $error("low byte of A not FE");
   brk_c: cover property (o_break_req);
   tag_c: cover property (o_tag_req);
   end_c: cover property ($fell(o_trace_active));
endmodule
`default_nettype wire

// ===== tb/ttu_cpu_model.sv
// cpu side model: bus cycles, flow changes, tag execution
`timescale 1ns/1ps
`default_nettype none
module ttu_cpu_model (
   input  wire logic             i_sys_clk,
   output var ttu_pkg::ttu_bus_t o_bus,
   output var ttu_pkg::ttu_cof_t o_cof,
   output logic                  o_tag_exec
);
   import ttu_pkg::*;
   initial o_bus = '0;
   initial o_cof = '0;
   initial o_tag_exec = 1'b0;
   // a released bus shows the inverse, so stale values never match
   task automatic bus(input ttu_addr_t a, input logic [7:0] d, input logic f);
      @(posedge i_sys_clk);
      o_bus <= '{1'b1, f, a, d};
      @(posedge i_sys_clk);
      o_bus <= '{1'b0, 1'b0, ~a, ~d};
   endtask
   task automatic flow(input ttu_cof_kind_t k, input ttu_addr_t s, input ttu_addr_t t);
      @(posedge i_sys_clk);
      o_cof <= '{1'b1, k, s, t};
      @(posedge i_sys_clk);
      o_cof <= '{1'b0, k, ~s, ~t};
   endtask
   task automatic tag;
      @(posedge i_sys_clk);
      o_tag_exec <= 1'b1;
      @(posedge i_sys_clk);
      o_tag_exec <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ===== tb/debug_trace_trigger_tb_top.sv
// self-checking bench for the trace and trigger unit
`timescale 1ns/1ps
`default_nettype none
module debug_trace_trigger_tb_top;
   import ttu_pkg::*;
   typedef struct {logic [3:0] m; logic f; logic [15:0] a, b, x1, x2; logic [7:0] d; logic e;} ttu_row_t;
   logic i_sys_clk = 1'b0, i_rst_n = 1'b0, i_mcu_rst = 1'b0, i_end_run_rst = 1'b0;
   logic i_secure = 1'b0, i_bdm_busy = 1'b0, i_reg_wr = 1'b0, i_reg_rd = 1'b0, i_tag_exec;
   logic [15:0] i_reg_addr = 16'h0000;
   logic [7:0] i_reg_wdata = 8'h00, o_reg_rdata;
   logic o_break_req, o_tag_req, o_trace_active;
   ttu_bus_t i_bus;
   ttu_cof_t i_cof;
   int fail_count = 0, tests_run = 0, nbrk = 0, ntag = 0;
   logic [7:0] rst_img [16] = '{8'hFF, 8'hFE, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                                8'h00, 8'h00, 8'h00, 8'h00, 8'hC0, 8'h40, 8'h01, 8'h00};
   // mode, full, A, B, first and second address, data, break expected
   ttu_row_t rows [12] = '{
      '{4'h0, 1'b0, 16'h1234, 16'h5678, 16'h1234, 16'h0000, 8'h00, 1'b1},
      '{4'h0, 1'b0, 16'h1234, 16'h5678, 16'h1235, 16'h0234, 8'h00, 1'b0},
      '{4'h1, 1'b0, 16'h1234, 16'h5678, 16'h0000, 16'h5678, 8'h00, 1'b1},
      '{4'h2, 1'b0, 16'h1234, 16'h5678, 16'h5678, 16'h1234, 8'h00, 1'b0},
      '{4'h2, 1'b0, 16'h1234, 16'h5678, 16'h1234, 16'h5678, 8'h00, 1'b1},
      '{4'h3, 1'b1, 16'h1234, 16'hAA55, 16'h1234, 16'h0000, 8'h55, 1'b1},
      '{4'h3, 1'b1, 16'h1234, 16'hAA55, 16'h1234, 16'h0000, 8'h54, 1'b0},
      '{4'h4, 1'b1, 16'h1234, 16'hAA55, 16'h1234, 16'h0000, 8'h54, 1'b1},
      '{4'h7, 1'b0, 16'h1000, 16'h2000, 16'h2000, 16'h0000, 8'h00, 1'b1},
      '{4'h7, 1'b0, 16'h1000, 16'h2000, 16'h2001, 16'h0FFF, 8'h00, 1'b0},
      '{4'h8, 1'b0, 16'h1000, 16'h2000, 16'h1800, 16'h2001, 8'h00, 1'b1},
      '{4'h8, 1'b0, 16'h1000, 16'h2000, 16'h1000, 16'h2000, 8'h00, 1'b0}};
   always #20 i_sys_clk = ~i_sys_clk;
   // pulse counters, cleared by the sequence before each case
   always @(posedge i_sys_clk) begin
      if (o_break_req === 1'b1) nbrk++;
      if (o_tag_req === 1'b1) ntag++;
   end
   ttu_core #(.FIFO_DEPTH(4)) dut (.i_sys_clk, .i_rst_n, .i_mcu_rst, .i_end_run_rst, .i_secure,
      .i_bdm_busy, .i_bus, .i_cof, .i_tag_exec, .i_reg_addr, .i_reg_wr, .i_reg_rd, .i_reg_wdata,
      .o_reg_rdata, .o_break_req, .o_tag_req, .o_trace_active);
   ttu_cpu_model cpu (.i_sys_clk, .o_bus(i_bus), .o_cof(i_cof), .o_tag_exec(i_tag_exec));
   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge i_sys_clk);
      i_reg_wr <= 1'b1;
      i_reg_addr <= a;
      i_reg_wdata <= d;
      @(posedge i_sys_clk);
      i_reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] exp);
      @(posedge i_sys_clk);
      i_reg_rd <= 1'b1;
      i_reg_addr <= a;
      @(posedge i_sys_clk);
      i_reg_rd <= 1'b0;
      #1 chk(o_reg_rdata, exp);
   endtask
   task automatic pulse(input logic m);
      @(posedge i_sys_clk);
      if (m) i_mcu_rst <= 1'b1;
      else i_end_run_rst <= 1'b1;
      @(posedge i_sys_clk);
      i_mcu_rst <= 1'b0;
      i_end_run_rst <= 1'b0;
   endtask
   // disarm first so the new mode is taken from idle
   task automatic setup(input logic [15:0] a, b, input logic [7:0] t, c);
      pulse(1'b1);
      wr(16'h301C, 8'h00);
      wr(16'h3010, a[15:8]);
      wr(16'h3011, a[7:0]);
      wr(16'h3012, b[15:8]);
      wr(16'h3013, b[7:0]);
      wr(16'h301D, t);
      wr(16'h301C, c);
      nbrk = 0;
      ntag = 0;
   endtask
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge i_sys_clk);
      fail_count++;
      conclude();
   end
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (10) @(posedge i_sys_clk);
      i_rst_n <= 1'b1;
      foreach (rows[i]) begin
         setup(rows[i].a, rows[i].b, {2'b01, rows[i].f, 1'b0, rows[i].m}, 8'hE0);
         cpu.bus({5'h00, rows[i].x1}, rows[i].d, 1'b0);
         cpu.bus({5'h00, rows[i].x2}, rows[i].d, 1'b0);
         repeat (2) @(posedge i_sys_clk);
         #1 chk(8'(nbrk), {7'h00, rows[i].e});
      end
      $display("trigger mode rows done");
      wr(16'h3011, 8'h00);
      pulse(1'b1);
      rd(16'h3011, 8'hFE);
      pulse(1'b1);
      for (int k = 0; k < 16; k++) if (k != 14) rd(16'h3010 + 16'(k), rst_img[k]);
      wr(16'h301F, 8'h55);
      rd(16'h301F, 8'h00);
      rd(16'h3020, 8'h00);
      wr(16'h3014, 8'hAB);
      pulse(1'b0);
      rd(16'h3014, 8'hAB);
      $display("register checks done");
      for (int k = 0; k < 2; k++) begin
         setup(16'h1234, 16'h5678, 8'h40, 8'hE0);
         i_secure <= (k == 0);
         i_bdm_busy <= (k == 1);
         cpu.bus(21'h01234, 8'h00, 1'b1);
         repeat (2) @(posedge i_sys_clk);
         #1 chk(8'(nbrk + ntag), 8'h00);
         i_secure <= 1'b0;
         i_bdm_busy <= 1'b0;
      end
      setup(16'h1234, 16'h5678, 8'h40, 8'hF0);
      cpu.bus(21'h01234, 8'h00, 1'b1);
      cpu.tag();
      repeat (2) @(posedge i_sys_clk);
      #1 chk(8'(ntag), 8'h01);
      #1 chk(8'(nbrk), 8'h01);
      setup(16'h0, 16'h0, 8'h40, 8'h88);
      cpu.bus(21'h0, 8'h0, 1'b0);
      repeat (2) @(posedge i_sys_clk);
      #1 chk(8'(nbrk), 8'h01);
      $display("gating and tag checks done");
      setup(16'h1234, 16'h5678, 8'h40, 8'hC0);
      cpu.bus(21'h01234, 8'h00, 1'b0);
      cpu.flow(CK_BRANCH, 21'h1ABCD, 21'h00111);
      cpu.flow(CK_RTS, 21'h00000, 21'h02468);
      repeat (3) @(posedge i_sys_clk);
      rd(16'h301F, 8'h02);
      rd(16'h301B, 8'h01);
      rd(16'h3016, 8'hAB);
      rd(16'h3017, 8'hCD);
      rd(16'h301B, 8'h00);
      rd(16'h3016, 8'h24);
      rd(16'h3017, 8'h68);
      setup(16'h1234, 16'h4000, 8'h45, 8'hC0);
      cpu.bus(21'h04000, 8'h5A, 1'b0);
      repeat (3) @(posedge i_sys_clk);
      rd(16'h301F, 8'h01);
      rd(16'h3016, 8'h00);
      rd(16'h3017, 8'h5A);
      $display("capture checks done");
      conclude();
   end
endmodule
bind ttu_core ttu_chk chk (.i_sys_clk, .i_rst_n, .i_mcu_rst, .i_end_run_rst, .i_secure,
   .i_bdm_busy, .i_bus, .i_cof, .i_tag_exec, .i_reg_addr, .i_reg_wr, .i_reg_rd, .i_reg_wdata,
   .o_reg_rdata, .o_break_req, .o_tag_req, .o_trace_active);
`default_nettype wire
